// ==== logic/ebh_hold.sv ====
// Primary-bus hold/release arbiter facing an external bus master
//
// What this block does
// - The request pin is taken asynchronously; a late edge may delay the answer by one cycle.
// - While hold_disable_bit is set, hold is left, the bus reclaimed and requests ignored.
// - During hold the core makes no bus access and stalls once it needs one that cannot be parked.
// - One bus write may be parked during hold; a read or a second write stalls the core.
// - Entering hold the strobe goes high first, then floats; it is driven again on exit.
// - In hold read/write, address and data float and are driven again on exit.
// - Acknowledge changes only on the core clock edge, both ways.
// - Acknowledge goes low after request low and rises one cycle after the synchronised request rises.
`timescale 1ns/100ps
`default_nettype none
module ebh_hold (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic bus_req_n_in,
  input wire logic hold_disable_bit_in,
  input wire logic core_req_valid_in,
  input wire ebh_pkg::ebh_req_t core_req_in,
  output logic core_req_ready_out,
  output logic core_stall_out,
  output logic bus_grant_ack_n_out,
  output ebh_pkg::ebh_pins_t pins_out,
  output ebh_pkg::ebh_oe_t pins_oe_out
);
  // =====================================================
  // Request synchronisation
  logic req_sync_n;

  ebh_sync u_sync (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .async_in(bus_req_n_in),
    .sync_out(req_sync_n)
  );

  // =====================================================
  // Arbiter state
  ebh_pkg::ebh_state_t state;
  ebh_pkg::ebh_state_t next_state;
  ebh_pkg::ebh_pins_t pins;
  ebh_pkg::ebh_pins_t next_pins;
  ebh_pkg::ebh_oe_t oe;
  ebh_pkg::ebh_oe_t next_oe;
  logic ack_n;
  logic next_ack_n;
  logic parked;
  logic next_parked;
  ebh_pkg::ebh_req_t park_req;
  ebh_pkg::ebh_req_t next_park_req;
  logic ready;
  logic next_ready;
  logic stall;
  logic next_stall;

  function automatic logic want_hold(input logic rq_n, input logic dis);
    want_hold = !rq_n && !dis;
  endfunction : want_hold

  // Start one single-cycle access with strobe low
  function automatic ebh_pkg::ebh_pins_t start_access(input ebh_pkg::ebh_req_t r);
    start_access.strobe_n = 1'h0;
    start_access.rw = !r.write;
    start_access.addr = r.addr;
    start_access.data = r.wdata;
  endfunction : start_access

  always_comb begin
    next_state = state;
    next_pins = pins;
    next_oe = oe;
    next_ack_n = ack_n;
    next_parked = parked;
    next_park_req = park_req;
    next_ready = 1'h0;
    next_stall = 1'h0;
    if (ce_in) begin
      case (state)
        ebh_pkg::EBH_IDLE: begin
          if (want_hold(req_sync_n, hold_disable_bit_in)) begin
            // Strobe is already high and driven here; float next
            next_state = ebh_pkg::EBH_PARK;
          end else if (core_req_valid_in) begin
            next_pins = start_access(core_req_in);
            next_ready = 1'h1;
            next_state = ebh_pkg::EBH_ACCESS;
          end
        end
        ebh_pkg::EBH_ACCESS: begin
          // Access always completes before hold is considered
          next_pins.strobe_n = 1'h1;
          next_state = ebh_pkg::EBH_IDLE;
        end
        ebh_pkg::EBH_PARK: begin
          if (hold_disable_bit_in) begin
            // Disable wins even after the grant was decided; nothing has floated yet
            next_state = ebh_pkg::EBH_IDLE;
          end else begin
            next_oe = '0;
            next_ack_n = 1'h0;
            next_state = ebh_pkg::EBH_HOLD;
          end
        end
        ebh_pkg::EBH_HOLD: begin
          if (!want_hold(req_sync_n, hold_disable_bit_in)) begin
            next_ack_n = 1'h1;
            next_oe = '1;
            next_state = ebh_pkg::EBH_IDLE;
          end else if (core_req_valid_in) begin
            if (core_req_in.write && !parked) begin
              next_parked = 1'h1;
              next_park_req = core_req_in;
              next_ready = 1'h1;
            end else begin
              next_stall = 1'h1;
            end
          end
        end
        default: begin
          next_state = ebh_pkg::EBH_IDLE;
        end
      endcase
      // Parked write drains first once the bus is back
      if (state == ebh_pkg::EBH_IDLE && parked && !want_hold(req_sync_n, hold_disable_bit_in)) begin
        next_pins = start_access(park_req);
        next_parked = 1'h0;
        next_ready = 1'h0;
        next_state = ebh_pkg::EBH_ACCESS;
      end
    end else begin
      next_ready = ready;
      next_stall = stall;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ebh_pkg::EBH_IDLE;
      pins <= '{strobe_n: ebh_pkg::STROBE_RST, rw: 1'h1, addr: '0, data: '0};
      oe <= '1;
      ack_n <= ebh_pkg::ACK_RST;
      parked <= 1'h0;
      park_req <= '0;
      ready <= 1'h0;
      stall <= 1'h0;
    end else begin
      state <= next_state;
      pins <= next_pins;
      oe <= next_oe;
      ack_n <= next_ack_n;
      parked <= next_parked;
      park_req <= next_park_req;
      ready <= next_ready;
      stall <= next_stall;
    end
  end

  assign core_req_ready_out = ready;
  assign core_stall_out = stall;
  assign bus_grant_ack_n_out = ack_n;
  assign pins_out = pins;
  assign pins_oe_out = oe;

  // =====================================================
  // Assertions
  property p_ack_needs_float;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      !ack_n |-> (oe == '0);
  endproperty
  a_ack_needs_float: assert property (p_ack_needs_float) else $error("Ack low while bus driven");

  property p_strobe_high_before_float;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      $fell(oe.strobe) |-> $past(pins.strobe_n) && pins.strobe_n;
  endproperty
  a_strobe_high_before_float: assert property (p_strobe_high_before_float) else $error("Strobe floated low");

  property p_disable_releases;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      (ce_in && hold_disable_bit_in && state == ebh_pkg::EBH_HOLD) |=> ack_n && (oe == '1);
  endproperty
  a_disable_releases: assert property (p_disable_releases) else $error("Hold kept while disabled");

  property p_no_grant_when_disabled;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      (hold_disable_bit_in && ack_n) |=> ack_n;
  endproperty
  a_no_grant_when_disabled: assert property (p_no_grant_when_disabled) else $error("Grant while disabled");

  property p_no_access_in_hold;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      !ack_n |-> pins.strobe_n;
  endproperty
  a_no_access_in_hold: assert property (p_no_access_in_hold) else $error("Access during hold");

  property p_grant_latency;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      (ce_in && state == ebh_pkg::EBH_IDLE && !parked && !req_sync_n && !hold_disable_bit_in)
        ##1 (ce_in && !hold_disable_bit_in)
        |=> !ack_n;
  endproperty
  a_grant_latency: assert property (p_grant_latency) else $error("Grant late");

  property p_release_latency;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      (ce_in && !ack_n && state == ebh_pkg::EBH_HOLD && req_sync_n) |=> ack_n;
  endproperty
  a_release_latency: assert property (p_release_latency) else $error("Release late");

  property p_access_completes;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      (state == ebh_pkg::EBH_ACCESS) |-> ack_n && !pins.strobe_n && oe.strobe;
  endproperty
  a_access_completes: assert property (p_access_completes) else $error("Access cut short");

  property p_second_write_stalls;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      (ce_in && state == ebh_pkg::EBH_HOLD && parked && core_req_valid_in && !req_sync_n
        && !hold_disable_bit_in) |=> stall && !ready;
  endproperty
  a_second_write_stalls: assert property (p_second_write_stalls) else $error("Second write not stalled");

  c_hold: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) $fell(ack_n));
  c_release: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) $rose(ack_n));
  c_park: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) $rose(parked));
  c_stall: cover property (@(posedge sys_clk_in) disable iff (!rstn_in) stall);
endmodule : ebh_hold
`default_nettype wire

// ==== logic/ebh_pkg.sv ====
// Package of constants and carrier types for the external bus hold/release block
package ebh_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam logic ACK_RST = 1'h1;
  localparam logic STROBE_RST = 1'h1;
  localparam logic [1:0] SYNC_RST = 2'h3;
  // Request must stay low this many core periods
  localparam int HOLD_MIN_PERIODS = 2;

  // Core-side request for one primary-bus access
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebh_req_t;

  // Primary-bus pin group driven by the device
  typedef struct packed {
    logic strobe_n;
    logic rw;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ebh_pins_t;

  // Output enables of the pin group, high while driving
  typedef struct packed {
    logic strobe;
    logic rw;
    logic addr;
    logic data;
  } ebh_oe_t;

  typedef enum logic [1:0] {
    EBH_IDLE = 2'h0,
    EBH_ACCESS = 2'h1,
    EBH_PARK = 2'h3,
    EBH_HOLD = 2'h2
  } ebh_state_t;
endpackage : ebh_pkg

// ==== logic/ebh_sync.sv ====
// Two-stage synchroniser for the asynchronous bus request pin
`timescale 1ns/100ps
`default_nettype none
module ebh_sync (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic async_in,
  output logic sync_out
);
  logic [1:0] stage;
  logic [1:0] next_stage;

  always_comb begin
    next_stage = stage;
    if (ce_in) begin
      next_stage = {stage[0], async_in};
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stage <= ebh_pkg::SYNC_RST;
    end else begin
      stage <= next_stage;
    end
  end

  assign sync_out = stage[1];
endmodule : ebh_sync
`default_nettype wire

// ==== verif/ebh_master_model.sv ====
// Behavioural external master that borrows the primary bus
`timescale 1ns/100ps
`default_nettype none
module ebh_master_model (
  input wire logic sys_clk_in,
  input wire logic bus_grant_ack_n_in,
  output logic bus_req_n_out
);
  initial bus_req_n_out = 1'b1;
  // ======
  // Request
  // Gives up on the grant after 20 cycles, yet keeps the pin low as long as asked
  task automatic hold_bus(input int len, input realtime skew, output int lat);
    @(negedge sys_clk_in);
    #(skew);
    bus_req_n_out = 1'b0;
    lat = 0;
    while (bus_grant_ack_n_in !== 1'b0 && lat < 20) begin
      @(negedge sys_clk_in);
      lat++;
    end
    repeat (len < ebh_pkg::HOLD_MIN_PERIODS ? ebh_pkg::HOLD_MIN_PERIODS : len) @(negedge sys_clk_in);
    bus_req_n_out = 1'b1;
  endtask : hold_bus
endmodule : ebh_master_model
`default_nettype wire

// ==== verif/tb_external_bus_hold_release.sv ====
// Self-checking bench for the primary-bus hold/release block
`timescale 1ns/100ps
`default_nettype none
module tb_external_bus_hold_release;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce_in = 1'b1;
  logic hold_disable_bit_in = 1'b0;
  logic core_req_valid_in = 1'b0;
  ebh_pkg::ebh_req_t core_req_in = '0;
  logic core_req_ready_out, core_stall_out, bus_grant_ack_n_out, bus_req_n;
  ebh_pkg::ebh_pins_t pins_out;
  ebh_pkg::ebh_oe_t pins_oe_out;
  int fail_count = 0;
  int n_checks = 0;
  int lat;
  always #2 sys_clk_in = ~sys_clk_in;
  ebh_hold u_ebh_hold (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .bus_req_n_in(bus_req_n),
    .hold_disable_bit_in(hold_disable_bit_in), .core_req_valid_in(core_req_valid_in), .core_req_in(core_req_in),
    .core_req_ready_out(core_req_ready_out), .core_stall_out(core_stall_out),
    .bus_grant_ack_n_out(bus_grant_ack_n_out), .pins_out(pins_out), .pins_oe_out(pins_oe_out));
  ebh_master_model u_ebh_master_model (.sys_clk_in(sys_clk_in), .bus_grant_ack_n_in(bus_grant_ack_n_out),
    .bus_req_n_out(bus_req_n));
  // ======
  // Helpers
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic wait_ack(input logic lvl);
    int n;
    n = 0;
    while (bus_grant_ack_n_out !== lvl) begin
      @(negedge sys_clk_in);
      n++;
      if (n > 20) begin
        fail_count++;
        tally_and_finish();
      end
    end
  endtask : wait_ack
  // Holds valid until ready or stall, then drops it at once
  task automatic core_op(input logic wr, input logic [23:0] a, input logic [31:0] d, output logic rdy);
    int n;
    core_req_in = '{write: wr, addr: a, wdata: d};
    core_req_valid_in = 1'b1;
    n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (core_req_ready_out !== 1'b1 && core_stall_out !== 1'b1 && n < 20);
    rdy = core_req_ready_out;
    core_req_valid_in = 1'b0;
    if (n >= 20) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : core_op
  // ======
  // Scenarios
  task automatic t_access;
    logic r;
    check({bus_grant_ack_n_out, pins_oe_out, core_req_ready_out, core_stall_out}, 7'h7c);
    check(pins_out, {ebh_pkg::STROBE_RST, 57'h100000000000000});
    core_op(1'b1, 24'h000123, 32'hdeadbeef, r);
    check(pins_out, {2'h0, 24'h000123, 32'hdeadbeef});
    @(negedge sys_clk_in);
    check(pins_out.strobe_n, 1'b1);
    core_op(1'b0, 24'hfffffe, 32'h0, r);
    check(pins_out[57:32], {2'h1, 24'hfffffe});
  endtask : t_access
  task automatic t_hold(input realtime skew);
    fork
      u_ebh_master_model.hold_bus(3, skew, lat);
      begin
        @(negedge sys_clk_in);
        wait_ack(1'b0);
        check(pins_oe_out, 4'h0);
        repeat (4) begin
          @(negedge sys_clk_in);
          check(bus_grant_ack_n_out, 1'b0);
        end
        wait_ack(1'b1);
        check(pins_oe_out, 4'hf);
      end
    join
    check(lat >= 3 && lat <= 5, 1'b1);
  endtask : t_hold
  task automatic t_race;
    logic r, prev;
    fork
      u_ebh_master_model.hold_bus(2, 0.0, lat);
      begin
        core_op(1'b1, 24'h00abcd, 32'h12345678, r);
        check({r, pins_out.strobe_n, pins_oe_out.strobe}, 3'h5);
        prev = 1'b0;
        for (int i = 0; i < 20 && pins_oe_out.strobe !== 1'b0; i++) begin
          prev = pins_out.strobe_n;
          @(negedge sys_clk_in);
        end
        check(prev, 1'b1);
      end
    join
    wait_ack(1'b1);
  endtask : t_race
  task automatic t_park;
    logic r;
    fork
      u_ebh_master_model.hold_bus(12, 0.0, lat);
      begin
        @(negedge sys_clk_in);
        wait_ack(1'b0);
        core_op(1'b1, 24'h00beef, 32'hcafef00d, r);
        check({r, pins_oe_out}, 5'h10);
        @(negedge sys_clk_in);
        core_op(1'b1, 24'h000001, 32'h1, r);
        check({r, core_stall_out}, 2'h1);
        @(negedge sys_clk_in);
        core_op(1'b0, 24'h000002, 32'h0, r);
        check({r, core_stall_out}, 2'h1);
      end
    join
    for (int i = 0; i < 20 && (pins_out.strobe_n !== 1'b0 || pins_oe_out.strobe !== 1'b1); i++)
      @(negedge sys_clk_in);
    check(pins_out, {2'h0, 24'h00beef, 32'hcafef00d});
  endtask : t_park
  task automatic t_disable;
    fork
      u_ebh_master_model.hold_bus(10, 0.0, lat);
      begin
        @(negedge sys_clk_in);
        wait_ack(1'b0);
        hold_disable_bit_in = 1'b1;
        @(negedge sys_clk_in);
        check({bus_grant_ack_n_out, pins_oe_out}, 5'h1f);
      end
    join
    u_ebh_master_model.hold_bus(4, 0.0, lat);
    check(lat, 20);
    // Let the released request settle before re-enabling, or a stale low would grant
    repeat (4) @(negedge sys_clk_in);
    hold_disable_bit_in = 1'b0;
  endtask : t_disable
  // Frozen clock enable must hold off the grant until it returns
  task automatic t_freeze;
    ce_in = 1'b0;
    fork
      u_ebh_master_model.hold_bus(4, 0.0, lat);
      begin
        repeat (6) begin
          @(negedge sys_clk_in);
          check({bus_grant_ack_n_out, pins_oe_out}, 5'h1f);
        end
        ce_in = 1'b1;
        wait_ack(1'b0);
        wait_ack(1'b1);
      end
    join
    check(lat, 9);
  endtask : t_freeze
  // Disable raised while the grant is already decided but not yet given
  task automatic t_late_disable;
    fork
      u_ebh_master_model.hold_bus(4, 0.0, lat);
      begin
        repeat (4) @(negedge sys_clk_in);
        hold_disable_bit_in = 1'b1;
        repeat (3) begin
          @(negedge sys_clk_in);
          check({bus_grant_ack_n_out, pins_oe_out}, 5'h1f);
        end
      end
    join
    check(lat, 20);
    repeat (4) @(negedge sys_clk_in);
    hold_disable_bit_in = 1'b0;
  endtask : t_late_disable
  initial begin
    repeat (16) @(negedge sys_clk_in);
    rstn_in = 1'b1;
    @(negedge sys_clk_in);
    t_access();
    t_hold(0.0);
    t_hold(1.7);
    t_race();
    t_park();
    t_disable();
    t_freeze();
    t_late_disable();
    tally_and_finish();
  end
endmodule : tb_external_bus_hold_release
`default_nettype wire
